//--- logic/cls_pkg.sv
`default_nettype none
package cls_pkg;
    // Data widths
    localparam int WORD_W = 32;
    localparam int DW_W = 64;
    localparam int KEY_W = 8;
    localparam int REG8_W = 8;
    // Local-store geometry
    localparam int LS_AW = 6;
    localparam int LS_DEPTH = 64;
    localparam logic [5:0] XLR_BASE = 6'h38;
    localparam int XLR_NUM = 8;
    localparam int XLR_IW = 3;
    // Address formation fields
    localparam int P_HI_W = 2;
    localparam int IND_LO_W = 4;
    localparam int BASE_HI_W = 4;
    localparam int CW_LO_W = 2;
    // Early control-word fields
    localparam int CW_LS_LO = 0;
    localparam int CW_EXT_LO = 8;
    localparam int CW_EXT_W = 8;
    // Access timing: longest time rounds down
    localparam int CLK_PERIOD_NS = 10;
    localparam int LS_ACCESS_NS = 24;
    localparam int LS_ACCESS_CYC = LS_ACCESS_NS / CLK_PERIOD_NS;
    localparam int LS_READ_LAT = 1;
    // Output buffer toward the external bus-in
    localparam int BUF_DEPTH = 2;
    // Control-word operations seen by this block
    typedef enum logic [2:0] {
        CLS_OP_NONE,
        CLS_OP_LS_READ,
        CLS_OP_LS_WRITE,
        CLS_OP_KEY_WRITE,
        CLS_OP_EXT_READ,
        CLS_OP_EXT_WRITE
    } cls_op_t;
    // Local-store address sources
    typedef enum logic [2:0] {
        CLS_AS_CW,
        CLS_AS_BASE,
        CLS_AS_INDIRECT,
        CLS_AS_SPECIAL,
        CLS_AS_CONSOLE
    } cls_asel_t;
endpackage : cls_pkg
`default_nettype wire

//--- logic/cls_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cls_mem_if;
    logic we;
    logic [cls_pkg::LS_AW-1:0] addr;
    logic [cls_pkg::WORD_W-1:0] wdata;
    logic [cls_pkg::WORD_W-1:0] rdata;
    modport ctrl(output we, output addr, output wdata, input rdata);
    modport mem(input we, input addr, input wdata, output rdata);
endinterface : cls_mem_if
`default_nettype wire

//--- logic/cls_stack_mem.sv
`timescale 1ns/100ps
`default_nettype none
module cls_stack_mem #(
    parameter int DEPTH = cls_pkg::LS_DEPTH
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    cls_mem_if.mem bus
);
    import cls_pkg::*;

    logic [WORD_W-1:0] words [DEPTH];
    logic [WORD_W-1:0] rdata;

    // Write port, no reset on the array
    always_ff @(posedge mclk_i) begin
        if (bus.we) begin
            words[bus.addr] <= bus.wdata;
        end
    end

    // Registered read port
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata <= '0;
        end else begin
            rdata <= words[bus.addr];
        end
    end

    assign bus.rdata = rdata;
endmodule : cls_stack_mem
`default_nettype wire

//--- logic/cls_datapath.sv
// How it works
// - Two identical 64-word stacks, A and B, built from one module.
// - Every write goes to the same address in both stacks.
// - Reads fetch both stacks and latch an error on mismatch.
// - A read word appears one cycle after the address, within 24 ns.
// - Address comes from control word, base, indirect, special, console, channel.
// - Extended registers sit at top addresses and feed operand registers.
// - Extended register reads share the path but skip the comparison.
// - Non-storage writes other than key writes go staging register, bus-out assembler, then stacks (local-store write) or bus-in buffer (external write).
// - Word written to stack A is latched and compared with staging data.
// - The same flush-through check covers control-word writes to external facilities, not storage words sent out.
// - Externals receive bus-out data; external data loads operand A.
// - Storage reads always deliver a whole doubleword.
// - A returned doubleword is latched before any word selection.
// - The even or odd word is selected and passed on alone.
// - A data word goes to local store or an external facility.
// - An instruction goes to buffers, extended registers, address adjust.
// - Control-word fields are forwarded early to source assemblers.
// - Backup takes the prime value now, retry the value one cycle older.
// - Staging data leaves on the following control-word cycle.
// - Bus-out assembler takes pre-assembly, key or staging data.
// - Indirect address joins base pointer high bits with the low four indirect bits.
`timescale 1ns/100ps
`default_nettype none
module cls_datapath #(
    parameter int BUF_DEPTH = cls_pkg::BUF_DEPTH
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic cw_valid_i,
    input wire cls_pkg::cls_op_t cw_op_i,
    input wire cls_pkg::cls_asel_t addr_sel_i,
    input wire logic [cls_pkg::LS_AW-1:0] cw_addr_i,
    input wire logic [cls_pkg::REG8_W-1:0] base_ptr_i,
    input wire logic [cls_pkg::REG8_W-1:0] indirect_i,
    input wire logic [cls_pkg::REG8_W-1:0] special_br_i,
    input wire logic [cls_pkg::LS_AW-1:0] console_cmd_i,
    input wire logic selch_force_i,
    input wire logic [cls_pkg::LS_AW-1:0] selch_addr_i,
    input wire logic rd_to_b_i,
    input wire logic stage_load_i,
    input wire logic [cls_pkg::WORD_W-1:0] stage_data_i,
    input wire logic [cls_pkg::KEY_W-1:0] key_i,
    input wire logic stor_valid_i,
    input wire logic [cls_pkg::DW_W-1:0] stor_dw_i,
    input wire logic stor_odd_i,
    input wire logic stor_instr_i,
    input wire logic stor_to_ext_i,
    input wire logic addr_adj_req_i,
    input wire logic [cls_pkg::WORD_W-1:0] ext_data_i,
    input wire logic ext_ready_i,
    input wire logic cw_readout_i,
    input wire logic [cls_pkg::WORD_W-1:0] cw_word_i,
    input wire logic [cls_pkg::WORD_W-1:0] prime_i,
    input wire logic err_clear_i,
    output logic cw_ready_o,
    output logic [cls_pkg::WORD_W-1:0] a_reg_o,
    output logic [cls_pkg::WORD_W-1:0] b_reg_o,
    output logic operand_valid_o,
    output logic [cls_pkg::WORD_W-1:0] external_bus_in_o,
    output logic ext_valid_o,
    output logic [cls_pkg::WORD_W-1:0] ibuf_word_o,
    output logic ibuf_valid_o,
    output logic addr_adj_valid_o,
    output logic [cls_pkg::LS_AW-1:0] ls_ctl_asm_o,
    output logic [cls_pkg::CW_EXT_W-1:0] ext_ctl_asm_o,
    output logic [cls_pkg::WORD_W-1:0] backup_o,
    output logic [cls_pkg::WORD_W-1:0] retry_o,
    output logic cmp_err_o,
    output logic ftc_err_o,
    output logic err_report_o
);
    import cls_pkg::*;

    localparam int BUF_PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int BUF_CW = $clog2(BUF_DEPTH + 1);

    cls_mem_if mem_if[2] ();

    // Staging, pre-assembly and check registers
    logic [WORD_W-1:0] stage_reg;
    logic [DW_W-1:0] pre_dw;
    logic pre_valid;
    logic pre_odd;
    logic pre_instr;
    logic pre_ext;
    logic pre_adj;
    logic [LS_AW-1:0] pre_addr;
    logic rd_pend;
    logic rd_xlr;
    logic rd_b;
    logic [XLR_IW-1:0] rd_idx;
    logic [WORD_W-1:0] flush_through_latches;
    logic [WORD_W-1:0] ftc_src;
    logic ftc_pend;
    logic [WORD_W-1:0] extended_local_regs [XLR_NUM];

    // Output buffer
    logic [WORD_W-1:0] buf_mem [BUF_DEPTH];
    logic [BUF_PW-1:0] buf_wr;
    logic [BUF_PW-1:0] buf_rd;
    logic [BUF_CW-1:0] buf_cnt;

    // Address formation
    wire logic [LS_AW-1:0] addr_base;
    wire logic [LS_AW-1:0] addr_ind;
    logic [LS_AW-1:0] addr_mux;
    wire logic [LS_AW-1:0] ls_addr;
    assign addr_base = {base_ptr_i[REG8_W-1 -: BASE_HI_W],
                        cw_addr_i[CW_LO_W-1:0]};
    assign addr_ind = {base_ptr_i[REG8_W-1 -: P_HI_W],
                       indirect_i[IND_LO_W-1:0]};

    // Address source selection
    always_comb begin
        unique case (addr_sel_i)
            CLS_AS_CW: addr_mux = cw_addr_i;
            CLS_AS_BASE: addr_mux = addr_base;
            CLS_AS_INDIRECT: addr_mux = addr_ind;
            CLS_AS_SPECIAL: addr_mux = special_br_i[LS_AW-1:0];
            CLS_AS_CONSOLE: addr_mux = console_cmd_i;
            default: addr_mux = cw_addr_i;
        endcase
    end
    assign ls_addr = selch_force_i ? selch_addr_i : addr_mux;

    // Handshake and operation decode
    wire logic buf_in_ready;
    wire logic cw_fire;
    wire logic op_ls_rd;
    wire logic op_ls_wr;
    wire logic op_key_wr;
    wire logic op_ext_rd;
    wire logic op_ext_wr;
    assign buf_in_ready = (buf_cnt != BUF_CW'(BUF_DEPTH));
    assign cw_ready_o = buf_in_ready & ~pre_valid;
    assign cw_fire = cw_valid_i & cw_ready_o;
    assign op_ls_rd = cw_fire & (cw_op_i == CLS_OP_LS_READ);
    assign op_ls_wr = cw_fire & (cw_op_i == CLS_OP_LS_WRITE);
    assign op_key_wr = cw_fire & (cw_op_i == CLS_OP_KEY_WRITE);
    assign op_ext_rd = cw_fire & (cw_op_i == CLS_OP_EXT_READ);
    assign op_ext_wr = cw_fire & (cw_op_i == CLS_OP_EXT_WRITE);

    // Word selection from the latched doubleword
    wire logic [WORD_W-1:0] sel_word;
    wire logic route_data;
    wire logic route_instr;
    assign sel_word = pre_odd ? pre_dw[WORD_W-1:0]
                              : pre_dw[DW_W-1 -: WORD_W];
    assign route_data = pre_valid & ~pre_instr;
    assign route_instr = pre_valid & pre_instr;

    // Bus-out assembler and write steering
    wire logic [WORD_W-1:0] bus_key;
    wire logic [WORD_W-1:0] store_bus_out;
    wire logic ls_we;
    wire logic [LS_AW-1:0] wr_addr;
    wire logic ext_push;
    wire logic from_stage;
    assign bus_key = {{(WORD_W-KEY_W){1'b0}}, key_i};
    assign store_bus_out = pre_valid ? sel_word :
                           op_key_wr ? bus_key : stage_reg;
    assign ls_we = (route_data & ~pre_ext) | op_ls_wr
                   | op_key_wr;
    assign wr_addr = pre_valid ? pre_addr : ls_addr;
    assign ext_push = (route_data & pre_ext) | op_ext_wr;
    assign from_stage = op_ls_wr | op_ext_wr;

    // Duplicate stacks, driven in common
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_stack
            assign mem_if[g].we = ls_we;
            assign mem_if[g].addr = ls_we ? wr_addr : ls_addr;
            assign mem_if[g].wdata = store_bus_out;
            cls_stack_mem #(
                .DEPTH(LS_DEPTH)
            ) u_stack (
                .mclk_i(mclk_i),
                .reset_i(reset_i),
                .bus(mem_if[g])
            );
        end
    endgenerate

    // Read result and comparison
    wire logic [WORD_W-1:0] word_a;
    wire logic [WORD_W-1:0] rd_word;
    wire logic cmp_set;
    wire logic ftc_set;
    wire logic rd_in_xlr;
    assign word_a = mem_if[0].rdata;
    assign rd_word = rd_xlr ? extended_local_regs[rd_idx]
                            : word_a;
    assign cmp_set = rd_pend & ~rd_xlr
                     & (word_a != mem_if[1].rdata);
    assign ftc_set = ftc_pend
                     & (flush_through_latches != ftc_src);
    assign rd_in_xlr = (ls_addr >= XLR_BASE);

    // Staging register
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            stage_reg <= '0;
        end else if (stage_load_i) begin
            stage_reg <= stage_data_i;
        end
    end

    // Pre-assembly latches take the whole doubleword
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pre_valid <= 1'b0;
            pre_dw <= '0;
            pre_odd <= 1'b0;
            pre_instr <= 1'b0;
            pre_ext <= 1'b0;
            pre_adj <= 1'b0;
            pre_addr <= '0;
        end else begin
            pre_valid <= stor_valid_i;
            if (stor_valid_i) begin
                pre_dw <= stor_dw_i;
                pre_odd <= stor_odd_i;
                pre_instr <= stor_instr_i;
                pre_ext <= stor_to_ext_i;
                pre_adj <= addr_adj_req_i;
                pre_addr <= ls_addr;
            end
        end
    end

    // Extended local registers loaded by instruction words
    generate
        for (g = 0; g < XLR_NUM; g++) begin : g_xlr
            always_ff @(posedge mclk_i) begin
                if (reset_i) begin
                    extended_local_regs[g] <= '0;
                end else if (route_instr
                             && pre_addr[XLR_IW-1:0] == XLR_IW'(g)) begin
                    extended_local_regs[g] <= sel_word;
                end
            end
        end
    endgenerate

    // Instruction buffer and address-adjust outputs
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ibuf_word_o <= '0;
            ibuf_valid_o <= 1'b0;
            addr_adj_valid_o <= 1'b0;
        end else begin
            ibuf_valid_o <= route_instr;
            addr_adj_valid_o <= route_instr & pre_adj;
            if (route_instr) begin
                ibuf_word_o <= sel_word;
            end
        end
    end

    // Read tracking for the registered stack outputs
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rd_pend <= 1'b0;
            rd_xlr <= 1'b0;
            rd_b <= 1'b0;
            rd_idx <= '0;
        end else begin
            rd_pend <= op_ls_rd;
            if (op_ls_rd) begin
                rd_xlr <= rd_in_xlr;
                rd_b <= rd_to_b_i;
                rd_idx <= ls_addr[XLR_IW-1:0];
            end
        end
    end

    // Operand registers A and B
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            a_reg_o <= '0;
            b_reg_o <= '0;
            operand_valid_o <= 1'b0;
        end else begin
            operand_valid_o <= rd_pend | op_ext_rd;
            if (op_ext_rd) begin
                a_reg_o <= ext_data_i;
            end else if (rd_pend && !rd_b) begin
                a_reg_o <= rd_word;
            end
            if (rd_pend && rd_b) begin
                b_reg_o <= rd_word;
            end
        end
    end

    // Flush-through capture of the word sent to stack A or out
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ftc_pend <= 1'b0;
            flush_through_latches <= '0;
            ftc_src <= '0;
        end else begin
            ftc_pend <= from_stage;
            if (from_stage) begin
                flush_through_latches <= mem_if[0].wdata;
                ftc_src <= stage_reg;
            end
        end
    end

    // Sticky errors, a new error wins over the clear
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cmp_err_o <= 1'b0;
            ftc_err_o <= 1'b0;
        end else begin
            cmp_err_o <= cmp_set | (cmp_err_o & ~err_clear_i);
            ftc_err_o <= ftc_set | (ftc_err_o & ~err_clear_i);
        end
    end
    assign err_report_o = cmp_err_o | ftc_err_o;

    // Early forwarding of control-word source fields
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ls_ctl_asm_o <= '0;
            ext_ctl_asm_o <= '0;
        end else if (cw_readout_i) begin
            ls_ctl_asm_o <= cw_word_i[CW_LS_LO +: LS_AW];
            ext_ctl_asm_o <= cw_word_i[CW_EXT_LO +: CW_EXT_W];
        end
    end

    // Backup and retry capture
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            backup_o <= '0;
            retry_o <= '0;
        end else begin
            backup_o <= prime_i;
            retry_o <= backup_o;
        end
    end

    // Two-entry buffer toward the external bus-in
    wire logic buf_pop;
    assign buf_pop = ext_valid_o & ext_ready_i;
    assign ext_valid_o = (buf_cnt != '0);
    assign external_bus_in_o = buf_mem[buf_rd];

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            buf_wr <= '0;
            buf_rd <= '0;
            buf_cnt <= '0;
        end else begin
            if (ext_push) begin
                buf_wr <= (buf_wr == BUF_PW'(BUF_DEPTH - 1)) ? '0
                          : buf_wr + 1'b1;
            end
            if (buf_pop) begin
                buf_rd <= (buf_rd == BUF_PW'(BUF_DEPTH - 1)) ? '0
                          : buf_rd + 1'b1;
            end
            buf_cnt <= buf_cnt + BUF_CW'(ext_push) - BUF_CW'(buf_pop);
        end
    end

    // Buffer storage
    always_ff @(posedge mclk_i) begin
        if (ext_push) begin
            buf_mem[buf_wr] <= store_bus_out;
        end
    end
endmodule : cls_datapath
`default_nettype wire

//--- testbench/cls_datapath_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module cls_datapath_monitor (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic cw_valid_i,
    input wire cls_pkg::cls_op_t cw_op_i,
    input wire logic cw_readout_i,
    input wire logic [cls_pkg::WORD_W-1:0] cw_word_i,
    input wire logic [cls_pkg::WORD_W-1:0] ext_data_i,
    input wire logic stor_valid_i,
    input wire logic stor_instr_i,
    input wire logic stor_odd_i,
    input wire logic [cls_pkg::DW_W-1:0] stor_dw_i,
    input wire logic [cls_pkg::WORD_W-1:0] prime_i,
    input wire logic err_clear_i,
    input wire logic cw_ready_o,
    input wire logic operand_valid_o,
    input wire logic [cls_pkg::WORD_W-1:0] a_reg_o,
    input wire logic ibuf_valid_o,
    input wire logic [cls_pkg::WORD_W-1:0] ibuf_word_o,
    input wire logic [cls_pkg::LS_AW-1:0] ls_ctl_asm_o,
    input wire logic [cls_pkg::CW_EXT_W-1:0] ext_ctl_asm_o,
    input wire logic [cls_pkg::WORD_W-1:0] backup_o,
    input wire logic [cls_pkg::WORD_W-1:0] retry_o,
    input wire logic cmp_err_o,
    input wire logic ftc_err_o,
    input wire logic err_report_o
);
    import cls_pkg::*;
    logic take;
    logic [WORD_W-1:0] cw_q;
    logic [WORD_W-1:0] sel_q;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // Control word accepted this edge
    assign take = cw_valid_i && cw_ready_o;
    // Last readout word and last selected storage word
    always_ff @(posedge mclk_i) begin
        cw_q <= cw_word_i;
        sel_q <= stor_odd_i ? stor_dw_i[31:0] : stor_dw_i[63:32];
    end
    chk_backup_prime: assert property (
        !$past(reset_i) |-> backup_o == $past(prime_i))
        else $error("backup value wrong");
    chk_retry_prime: assert property (
        !$past(reset_i) && !$past(reset_i, 2)
        |-> retry_o == $past(prime_i, 2))
        else $error("retry value wrong");
    chk_ls_read_ans: assert property (
        take && cw_op_i == CLS_OP_LS_READ |-> ##2 operand_valid_o)
        else $error("local store read not answered");
    chk_ext_read_ans: assert property (
        take && cw_op_i == CLS_OP_EXT_READ
        |=> operand_valid_o && a_reg_o == $past(ext_data_i))
        else $error("external read not in operand a");
    chk_early_fields: assert property (
        cw_readout_i |=> ls_ctl_asm_o == cw_q[5:0]
        && ext_ctl_asm_o == cw_q[15:8])
        else $error("early control fields wrong");
    chk_dw_hold: assert property (
        stor_valid_i |=> !cw_ready_o)
        else $error("ready high while doubleword latched");
    chk_instr_word: assert property (
        stor_valid_i && stor_instr_i
        |-> ##2 ibuf_valid_o && ibuf_word_o == $past(sel_q))
        else $error("instruction word not selected");
    chk_cmp_sticky: assert property (
        cmp_err_o && !err_clear_i |=> cmp_err_o)
        else $error("stack mismatch flag lost");
    chk_ftc_sticky: assert property (
        ftc_err_o && !err_clear_i |=> ftc_err_o)
        else $error("flush-through flag lost");
    chk_err_summary: assert property (
        err_report_o == (cmp_err_o || ftc_err_o))
        else $error("error report not the or of flags");
endmodule : cls_datapath_monitor
bind cls_datapath cls_datapath_monitor u_mon (.*);
`default_nettype wire

//--- testbench/cls_ext_sink.sv
`timescale 1ns/100ps
`default_nettype none
module cls_ext_sink (
    input wire logic reset_i,
    input wire logic valid_i,
    input wire logic stall_i,
    output logic ready_o,
    output logic take_o
);
    import cls_pkg::*;
    // External facility takes a word unless stalled
    assign ready_o = !stall_i && !reset_i;
    assign take_o = valid_i && ready_o;
endmodule : cls_ext_sink
`default_nettype wire

//--- testbench/cls_datapath_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cls_datapath_tb;
    import cls_pkg::*;
    logic mclk_i, reset_i, cw_valid_i, selch_force_i, rd_to_b_i;
    logic stage_load_i, stor_valid_i, stor_odd_i, stor_instr_i;
    logic stor_to_ext_i, addr_adj_req_i, ext_ready_i, cw_readout_i;
    logic err_clear_i, stall, take;
    cls_op_t cw_op_i;
    cls_asel_t addr_sel_i;
    logic [5:0] cw_addr_i, console_cmd_i, selch_addr_i, ls_ctl_asm_o;
    logic [7:0] base_ptr_i, indirect_i, special_br_i, key_i;
    logic [7:0] ext_ctl_asm_o;
    logic [31:0] stage_data_i, ext_data_i, cw_word_i, prime_i;
    logic [31:0] a_reg_o, b_reg_o, external_bus_in_o, ibuf_word_o;
    logic [31:0] backup_o, retry_o;
    logic [63:0] stor_dw_i;
    logic cw_ready_o, operand_valid_o, ext_valid_o, ibuf_valid_o;
    logic addr_adj_valid_o, cmp_err_o, ftc_err_o, err_report_o;
    int fail_count, n_compared;
    int ls[64];
    int xlr[8];
    int exq[$];
    cls_datapath dut (.*);
    cls_ext_sink u_sink (.reset_i, .valid_i(ext_valid_o),
        .stall_i(stall), .ready_o(ext_ready_i), .take_o(take));
    // Clock and free-running prime register
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) #1 prime_i = $urandom;
    // Words on external bus-in in push order
    always @(posedge mclk_i) if (take) begin
        if (exq.size() == 0) chk("bus_in_extra", 0, 1);
        else chk("bus_in", exq.pop_front(), external_bus_in_o);
    end
    task automatic cyc;
        @(posedge mclk_i);
        #1;
    endtask : cyc
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic results;
        if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    task automatic cw(input cls_op_t op, input cls_asel_t s);
        int i;
        cyc;
        stage_load_i = 0;
        cw_op_i = op;
        addr_sel_i = s;
        cw_valid_i = 1;
        for (i = 0; i < 20 && cw_ready_o !== 1'b1; i++) cyc;
        if (i == 20) begin
            fail_count++;
            results;
        end
        cyc;
        cw_valid_i = 0;
    endtask : cw
    function automatic logic [5:0] fa(input cls_asel_t s);
        if (selch_force_i) return selch_addr_i;
        case (s)
            CLS_AS_BASE: return {base_ptr_i[7:4], cw_addr_i[1:0]};
            CLS_AS_INDIRECT: return {base_ptr_i[7:6], indirect_i[3:0]};
            CLS_AS_SPECIAL: return special_br_i[5:0];
            CLS_AS_CONSOLE: return console_cmd_i;
            default: return cw_addr_i;
        endcase
    endfunction : fa
    task automatic rd(input cls_asel_t s);
        logic [5:0] a;
        a = fa(s);
        rd_to_b_i = $urandom;
        cw(CLS_OP_LS_READ, s);
        cyc;
        chk("operand_valid", 1, operand_valid_o);
        chk("read_word", a >= 6'h38 ? xlr[a[2:0]] : ls[a],
            rd_to_b_i ? b_reg_o : a_reg_o);
    endtask : rd
    task automatic wr(input logic [5:0] a, input logic [31:0] d,
            input cls_op_t op);
        stage_data_i = d;
        stage_load_i = 1;
        cw_addr_i = a;
        selch_force_i = 0;
        cw(op, CLS_AS_CW);
        if (op == CLS_OP_LS_WRITE) ls[a] = d;
        else exq.push_back(d);
    endtask : wr
    // m holds instruction, to-external and adjust-request flags
    task automatic st(input logic [5:0] a, input logic [2:0] m);
        logic [31:0] w;
        cyc;
        stor_dw_i = {$urandom, $urandom};
        stor_odd_i = $urandom;
        w = stor_odd_i ? stor_dw_i[31:0] : stor_dw_i[63:32];
        {stor_instr_i, stor_to_ext_i, addr_adj_req_i} = m;
        cw_addr_i = a;
        addr_sel_i = CLS_AS_CW;
        selch_force_i = 0;
        stor_valid_i = 1;
        cyc;
        stor_valid_i = 0;
        chk("ready_after_dw", 0, cw_ready_o);
        cyc;
        chk("ibuf_valid", m[2], ibuf_valid_o);
        chk("adj_valid", m[2] & m[0], addr_adj_valid_o);
        if (m[2]) xlr[a[2:0]] = w;
        else if (m[1]) exq.push_back(w);
        else ls[a] = w;
    endtask : st
    // Main sequence
    initial begin
        void'($urandom(32'hf9f7));
        {mclk_i, cw_valid_i, selch_force_i, rd_to_b_i, stage_load_i} = 0;
        {stor_valid_i, stor_odd_i, stor_instr_i, stor_to_ext_i} = 0;
        {addr_adj_req_i, cw_readout_i, err_clear_i, stall} = 0;
        {cw_addr_i, console_cmd_i, selch_addr_i, key_i} = 0;
        {base_ptr_i, indirect_i, special_br_i, stor_dw_i} = 0;
        {stage_data_i, ext_data_i, cw_word_i, prime_i} = 0;
        cw_op_i = CLS_OP_NONE;
        addr_sel_i = CLS_AS_CW;
        reset_i = 1;
        repeat (3) @(posedge mclk_i);
        #1 reset_i = 0;
        for (int i = 0; i < 56; i++) wr(6'(i), $urandom, CLS_OP_LS_WRITE);
        for (int i = 0; i < 60; i++) begin
            base_ptr_i = 8'($urandom) & 8'hbf;
            indirect_i = $urandom;
            special_br_i = 8'($urandom) & 8'h2f;
            console_cmd_i = 6'($urandom) & 6'h2f;
            cw_addr_i = 6'($urandom) & 6'h2f;
            selch_addr_i = 6'($urandom) & 6'h2f;
            selch_force_i = (i % 7 == 6);
            rd(cls_asel_t'(3'(i % 5)));
        end
        for (int i = 0; i < 8; i++) begin
            st(6'h38 | 6'(i), {2'b10, i[0]});
            rd(CLS_AS_CW);
            st(6'(i * 5), 3'b000);
            rd(CLS_AS_CW);
        end
        chk("stack_compare", 0, cmp_err_o);
        ext_data_i = $urandom;
        cw(CLS_OP_EXT_READ, CLS_AS_CW);
        chk("ext_read", ext_data_i, a_reg_o);
        stall = 1;
        wr(6'h01, $urandom, CLS_OP_EXT_WRITE);
        wr(6'h02, $urandom, CLS_OP_EXT_WRITE);
        cyc;
        chk("ready_when_full", 0, cw_ready_o);
        stall = 0;
        st(6'h11, 3'b010);
        wr(6'h03, $urandom, CLS_OP_EXT_WRITE);
        key_i = $urandom;
        cw_addr_i = 6'h20;
        cw(CLS_OP_KEY_WRITE, CLS_AS_CW);
        ls[32] = key_i;
        rd(CLS_AS_CW);
        cw_word_i = $urandom;
        cw_readout_i = 1;
        cyc;
        cw_readout_i = 0;
        chk("ls_ctl", cw_word_i[5:0], ls_ctl_asm_o);
        chk("ext_ctl", cw_word_i[15:8], ext_ctl_asm_o);
        repeat (6) cyc;
        chk("bus_in_left", 0, exq.size());
        chk("flush_through", 0, ftc_err_o);
        err_clear_i = 1;
        cyc;
        err_clear_i = 0;
        chk("err_report", 0, err_report_o);
        results;
    end
endmodule : cls_datapath_tb
`default_nettype wire
